/* hw/cpu_transfer_arith_datapath.sv */
// Execution datapath for moves, stack transfers, add/sub, adjust and multiply.
// Assumes an APB master; memory reads arrive through DATA, stores leave via MADDR/MWDATA.
// Function
// - eight 32-bit registers, word and byte views
// - any long register serves data or address
// - flags are negative, zero, overflow, carry
// - operand fields are 3, 8, 16, 24 bits
// - move register, memory or immediate, all sizes
// - peripheral-synchronised moves are unavailable instructions
// - pop reads at stack, then advances it
// - push retreats stack, then writes there
// - add and subtract, register or immediate source
// - no immediate byte subtraction
// - byte add/subtract including carry flag input
// - increment/decrement by 1 or 2, bytes 1
// - address adjust by 1, 2 or 4
// - decimal adjust byte using flags into BCD
// - unsigned 8x8 and 16x16 multiply
// - signed 8x8 and 16x16 multiply
//
// The APB interface to the registers and the placing of the registers were decided locally.
module cpu_transfer_arith_datapath (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB request
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    // APB answer
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    dp_pkg::state_type s;
    dp_pkg::state_type next_s;
    logic acc;
    logic cmd_go;
    dp_pkg::cmd_type cw;

    function automatic int msb(dp_pkg::size_type z);
        case (z)
            dp_pkg::byte_size: return 7;
            dp_pkg::word_size: return 15;
            default: return 31;
        endcase
    endfunction: msb

    function automatic logic [31:0] fit(dp_pkg::size_type z, logic [31:0] v);
        case (z)
            dp_pkg::byte_size: return {24'h000000, v[7:0]};
            dp_pkg::word_size: return {16'h0000, v[15:0]};
            default: return v;
        endcase
    endfunction: fit

    // Code 8..15 picks the low byte or the upper half
    function automatic logic [31:0] get(logic [7:0][31:0] g, dp_pkg::size_type z, logic [3:0] i);
        case (z)
            dp_pkg::byte_size: return {24'h000000, i[3] ? g[i[2:0]][7:0] : g[i[2:0]][15:8]};
            dp_pkg::word_size: return {16'h0000, i[3] ? g[i[2:0]][31:16] : g[i[2:0]][15:0]};
            default: return g[i[2:0]];
        endcase
    endfunction: get

    function automatic logic [31:0] put(logic [31:0] old, dp_pkg::size_type z, logic [3:0] i, logic [31:0] v);
        case (z)
            dp_pkg::byte_size: return i[3] ? {old[31:8], v[7:0]} : {old[31:16], v[7:0], old[7:0]};
            dp_pkg::word_size: return i[3] ? {v[15:0], old[15:0]} : {old[31:16], v[15:0]};
            default: return v;
        endcase
    endfunction: put

    // Sign-extends a 3-, 8- or 16-bit displacement field; a 24-bit absolute address field is zero-extended
    function automatic logic [31:0] ext(dp_pkg::len_type l, logic [31:0] v);
        case (l)
            dp_pkg::len_3: return {{29{v[2]}}, v[2:0]};
            dp_pkg::len_8: return {{24{v[7]}}, v[7:0]};
            dp_pkg::len_16: return {{16{v[15]}}, v[15:0]};
            default: return {8'h00, v[23:0]};
        endcase
    endfunction: ext

    function automatic logic [31:0] merge(logic [31:0] old, logic [31:0] v, logic [3:0] st);
        logic [31:0] o;
        o = old;
        for (int k = 0; k < 4; k++)
        begin
            if (st[k])
            begin
                o[k*8 +: 8] = v[k*8 +: 8];
            end
        end
        return o;
    endfunction: merge

    // Operands arrive already cut to the operation size
    function automatic dp_pkg::result_type arith(dp_pkg::size_type z, logic [31:0] a, logic [31:0] b,
                                                 logic ci, logic sub);
        dp_pkg::result_type o;
        logic [32:0] w;
        int t;
        t = msb(z);
        w = sub ? {1'b0, a} - {1'b0, b} - {32'h0, ci} : {1'b0, a} + {1'b0, b} + {32'h0, ci};
        o.r = fit(z, w[31:0]);
        o.f.n = o.r[t];
        o.f.z = (o.r == 32'h0000_0000);
        o.f.v = (sub ? (a[t] != b[t]) : (a[t] == b[t])) & (o.r[t] != a[t]);
        o.f.c = w[t + 1];
        return o;
    endfunction: arith

    assign acc = psel & penable & s.ready & pwrite;
    assign cmd_go = acc & (paddr == dp_pkg::OFS_CMD);
    assign cw = dp_pkg::cmd_type'(pwdata);

    always_comb
    begin
        logic bad;
        logic [31:0] a;
        logic [31:0] b;
        logic [31:0] v;
        logic [31:0] amt;
        logic [31:0] step;
        logic [31:0] disp;
        logic [7:0] adj;
        logic hi;
        dp_pkg::result_type ar;
        bad = 1'b0;
        a = get(s.gpr, cw.size, cw.dst);
        b = cw.imm ? fit(cw.size, s.data) : get(s.gpr, cw.size, cw.src);
        v = 32'h0000_0000;
        amt = {28'h0000000, cw.src};
        step = (cw.size == dp_pkg::long_size) ? dp_pkg::STEP_LONG : dp_pkg::STEP_WORD;
        disp = ext(cw.len, s.disp);
        adj = 8'h00;
        hi = 1'b0;
        ar = '0;
        next_s = s;
        next_s.ready = psel & ~penable;
        next_s.slverr = 1'b0;
        // Read data and error are settled in the setup cycle
        if (psel & ~penable)
        begin
            next_s.rdata = 32'h0000_0000;
            if (paddr[7:5] == dp_pkg::GPR_PAGE && paddr[1:0] == 2'h0)
            begin
                next_s.rdata = s.gpr[paddr[4:2]];
            end
            else
            begin
                case (paddr)
                    dp_pkg::OFS_CMD: next_s.rdata = s.cmd;
                    dp_pkg::OFS_DATA: next_s.rdata = s.data;
                    dp_pkg::OFS_FLAGS: next_s.rdata = {28'h0000000, s.flags};
                    dp_pkg::OFS_STATUS: next_s.rdata = {31'h00000000, s.illegal};
                    dp_pkg::OFS_MADDR: next_s.rdata = s.maddr;
                    dp_pkg::OFS_MWDATA: next_s.rdata = s.mwdata;
                    dp_pkg::OFS_DISP: next_s.rdata = s.disp;
                    default: next_s.slverr = 1'b1;
                endcase
            end
        end
        if (acc)
        begin
            if (paddr[7:5] == dp_pkg::GPR_PAGE && paddr[1:0] == 2'h0)
            begin
                next_s.gpr[paddr[4:2]] = merge(s.gpr[paddr[4:2]], pwdata, pstrb);
            end
            case (paddr)
                dp_pkg::OFS_DATA: next_s.data = merge(s.data, pwdata, pstrb);
                dp_pkg::OFS_DISP: next_s.disp = merge(s.disp, pwdata, pstrb);
                dp_pkg::OFS_FLAGS: next_s.flags = pstrb[0] ? pwdata[3:0] : s.flags;
                dp_pkg::OFS_STATUS: next_s.illegal = s.illegal & ~pwdata[dp_pkg::STATUS_ILLEGAL];
                default: ;
            endcase
        end
        if (cmd_go)
        begin
            next_s.cmd = pwdata;
            case (cw.op)
                dp_pkg::mov_reg, dp_pkg::mov_load:
                begin
                    v = (cw.op == dp_pkg::mov_reg) ? b : fit(cw.size, s.data);
                    if (cw.op == dp_pkg::mov_load)
                    begin
                        next_s.maddr = cw.imm ? disp : s.gpr[cw.src[2:0]] + disp;
                    end
                    next_s.gpr[cw.dst[2:0]] = put(s.gpr[cw.dst[2:0]], cw.size, cw.dst, v);
                    next_s.flags = {v[msb(cw.size)], v == 32'h0000_0000, 1'b0, s.flags.c};
                end
                dp_pkg::mov_store:
                begin
                    next_s.maddr = cw.imm ? disp : s.gpr[cw.dst[2:0]] + disp;
                    v = get(s.gpr, cw.size, cw.src);
                    next_s.mwdata = v;
                    next_s.flags = {v[msb(cw.size)], v == 32'h0000_0000, 1'b0, s.flags.c};
                end
                dp_pkg::pop_reg:
                begin
                    bad = (cw.size == dp_pkg::byte_size);
                    v = fit(cw.size, s.data);
                    next_s.maddr = s.gpr[dp_pkg::SP_INDEX];
                    next_s.gpr[cw.dst[2:0]] = put(s.gpr[cw.dst[2:0]], cw.size, cw.dst, v);
                    next_s.gpr[dp_pkg::SP_INDEX] = next_s.gpr[dp_pkg::SP_INDEX] + step;
                    next_s.flags = {v[msb(cw.size)], v == 32'h0000_0000, 1'b0, s.flags.c};
                end
                dp_pkg::push_reg:
                begin
                    bad = (cw.size == dp_pkg::byte_size);
                    v = get(s.gpr, cw.size, cw.src);
                    next_s.gpr[dp_pkg::SP_INDEX] = s.gpr[dp_pkg::SP_INDEX] - step;
                    next_s.maddr = s.gpr[dp_pkg::SP_INDEX] - step;
                    next_s.mwdata = v;
                    next_s.flags = {v[msb(cw.size)], v == 32'h0000_0000, 1'b0, s.flags.c};
                end
                dp_pkg::add_plain, dp_pkg::sub_plain:
                begin
                    bad = (cw.op == dp_pkg::sub_plain) & cw.imm & (cw.size == dp_pkg::byte_size);
                    ar = arith(cw.size, a, b, 1'b0, cw.op == dp_pkg::sub_plain);
                    next_s.gpr[cw.dst[2:0]] = put(s.gpr[cw.dst[2:0]], cw.size, cw.dst, ar.r);
                    next_s.flags = ar.f;
                end
                dp_pkg::add_with_carry, dp_pkg::subtract_with_borrow:
                begin
                    bad = (cw.size != dp_pkg::byte_size);
                    ar = arith(cw.size, a, b, s.flags.c, cw.op == dp_pkg::subtract_with_borrow);
                    next_s.gpr[cw.dst[2:0]] = put(s.gpr[cw.dst[2:0]], cw.size, cw.dst, ar.r);
                    // Zero only survives a chain of zero results
                    next_s.flags = {ar.f.n, ar.f.z & s.flags.z, ar.f.v, ar.f.c};
                end
                dp_pkg::inc_reg, dp_pkg::dec_reg:
                begin
                    bad = (amt != 32'h1) & ((amt != 32'h2) | (cw.size == dp_pkg::byte_size));
                    ar = arith(cw.size, a, amt, 1'b0, cw.op == dp_pkg::dec_reg);
                    next_s.gpr[cw.dst[2:0]] = put(s.gpr[cw.dst[2:0]], cw.size, cw.dst, ar.r);
                    next_s.flags = {ar.f.n, ar.f.z, ar.f.v, s.flags.c};
                end
                dp_pkg::address_adjust_add, dp_pkg::address_adjust_sub:
                begin
                    bad = (cw.size != dp_pkg::long_size) | ((amt != 32'h1) & (amt != 32'h2) & (amt != 32'h4));
                    next_s.gpr[cw.dst[2:0]] = (cw.op == dp_pkg::address_adjust_add) ?
                        s.gpr[cw.dst[2:0]] + amt : s.gpr[cw.dst[2:0]] - amt;
                end
                dp_pkg::decimal_adjust_add, dp_pkg::decimal_adjust_sub:
                begin
                    bad = (cw.size != dp_pkg::byte_size);
                    hi = s.flags.c | ((cw.op == dp_pkg::decimal_adjust_add) & (a[7:0] > dp_pkg::BCD_LIMIT));
                    adj = {hi ? dp_pkg::BCD_FIX : 4'h0, (a[3:0] > dp_pkg::NIBBLE_LIMIT) ? dp_pkg::BCD_FIX : 4'h0};
                    v = {24'h000000, (cw.op == dp_pkg::decimal_adjust_add) ? a[7:0] + adj : a[7:0] - adj};
                    next_s.gpr[cw.dst[2:0]] = put(s.gpr[cw.dst[2:0]], cw.size, cw.dst, v);
                    next_s.flags = {v[7], v == 32'h0000_0000, s.flags.v, hi};
                end
                dp_pkg::multiply_unsigned, dp_pkg::multiply_signed:
                begin
                    bad = (cw.size == dp_pkg::long_size);
                    if (cw.size == dp_pkg::byte_size)
                    begin
                        a = get(s.gpr, dp_pkg::word_size, cw.dst);
                        // Operands widened to the product width first, so no product bit is lost
                        v = {16'h0000, (cw.op == dp_pkg::multiply_signed) ?
                            {{8{a[7]}}, a[7:0]} * {{8{b[7]}}, b[7:0]} :
                            {8'h00, a[7:0]} * {8'h00, b[7:0]}};
                        next_s.gpr[cw.dst[2:0]] = put(s.gpr[cw.dst[2:0]], dp_pkg::word_size, cw.dst, v);
                        next_s.flags = {v[15], v == 32'h0000_0000, s.flags.v, s.flags.c};
                    end
                    else
                    begin
                        a = s.gpr[cw.dst[2:0]];
                        v = (cw.op == dp_pkg::multiply_signed) ?
                            {{16{a[15]}}, a[15:0]} * {{16{b[15]}}, b[15:0]} :
                            {16'h0000, a[15:0]} * {16'h0000, b[15:0]};
                        next_s.gpr[cw.dst[2:0]] = v;
                        next_s.flags = {v[31], v == 32'h0000_0000, s.flags.v, s.flags.c};
                    end
                    // Only the signed form reports sign and zero
                    if (cw.op == dp_pkg::multiply_unsigned)
                    begin
                        next_s.flags = s.flags;
                    end
                end
                default: bad = 1'b1;
            endcase
            // A refused command leaves the general registers, flags, MADDR and MWDATA untouched
            if (bad)
            begin
                next_s.gpr = s.gpr;
                next_s.flags = s.flags;
                next_s.maddr = s.maddr;
                next_s.mwdata = s.mwdata;
                next_s.illegal = 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s <= dp_pkg::STATE_RESET;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign prdata = s.rdata;
    assign pready = s.ready;
    assign pslverr = s.slverr;

    a_ready_after_setup: assert property (@(posedge pclk) disable iff (!presetn)
        psel && !penable |=> pready) else $error("access phase not answered at once");
    a_sync_move_refused: assert property (@(posedge pclk) disable iff (!presetn)
        cmd_go && cw.op == dp_pkg::move_to_peripheral_sync |=> s.illegal && s.gpr == $past(s.gpr))
        else $error("peripheral-synchronised move was executed");
    a_sub_byte_imm: assert property (@(posedge pclk) disable iff (!presetn)
        cmd_go && cw.op == dp_pkg::sub_plain && cw.imm && cw.size == dp_pkg::byte_size
        |=> s.illegal && s.flags == $past(s.flags)) else $error("immediate byte subtract accepted");
    a_pop_advance: assert property (@(posedge pclk) disable iff (!presetn)
        cmd_go && cw.op == dp_pkg::pop_reg && cw.size == dp_pkg::word_size && cw.dst[2:0] != 3'h7
        |=> s.gpr[7] == $past(s.gpr[7]) + 32'h2 && s.maddr == $past(s.gpr[7]))
        else $error("pop did not advance stack by two");
    a_push_retreat: assert property (@(posedge pclk) disable iff (!presetn)
        cmd_go && cw.op == dp_pkg::push_reg && cw.size == dp_pkg::long_size
        |=> s.gpr[7] == $past(s.gpr[7]) - 32'h4 && s.maddr == s.gpr[7])
        else $error("push did not retreat stack by four");
    a_adjust_by_four: assert property (@(posedge pclk) disable iff (!presetn)
        cmd_go && cw.op == dp_pkg::address_adjust_add && cw.size == dp_pkg::long_size && cw.src == 4'h4
        && cw.dst == 4'h0 |=> s.gpr[0] == $past(s.gpr[0]) + 32'h4) else $error("address adjust wrong");
    a_byte_keeps_upper: assert property (@(posedge pclk) disable iff (!presetn)
        cmd_go && cw.op == dp_pkg::inc_reg && cw.size == dp_pkg::byte_size && cw.dst[2:0] == 3'h0
        |=> s.gpr[0][31:16] == $past(s.gpr[0][31:16])) else $error("byte write disturbed upper half");
    a_inc_byte_two: assert property (@(posedge pclk) disable iff (!presetn)
        cmd_go && cw.op == dp_pkg::inc_reg && cw.size == dp_pkg::byte_size && cw.src == 4'h2
        |=> s.illegal ##1 s.illegal) else $error("byte increment by two accepted");
    a_mul_byte_unsigned: assert property (@(posedge pclk) disable iff (!presetn)
        cmd_go && cw.op == dp_pkg::multiply_unsigned && cw.size == dp_pkg::byte_size && cw.dst == 4'h0
        && cw.src == 4'h9 && !cw.imm
        |=> s.gpr[0][15:0] == {8'h00, $past(s.gpr[0][7:0])} * {8'h00, $past(s.gpr[1][7:0])})
        else $error("unsigned byte product wrong");
    a_add_zero_flag: assert property (@(posedge pclk) disable iff (!presetn)
        cmd_go && cw.op == dp_pkg::add_plain && cw.size == dp_pkg::long_size && cw.dst == 4'h0
        |=> s.flags.z == (s.gpr[0] == 32'h0) && s.flags.n == s.gpr[0][31]) else $error("add flags wrong");
endmodule: cpu_transfer_arith_datapath

/* hw/dp_pkg.sv */
// Constants and types for the transfer and arithmetic execution datapath.
// Assumes an APB master with 8-bit byte addresses, 32-bit data and byte strobes.
package dp_pkg;
    // Register byte offsets, one aligned word each
    localparam logic [7:0] OFS_CMD = 8'h00;
    localparam logic [7:0] OFS_DATA = 8'h04;
    localparam logic [7:0] OFS_FLAGS = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0C;
    localparam logic [7:0] OFS_MADDR = 8'h10;
    localparam logic [7:0] OFS_MWDATA = 8'h14;
    localparam logic [7:0] OFS_DISP = 8'h18;
    // General registers sit at 0x20 + 4 * n
    localparam logic [2:0] GPR_PAGE = 3'h1;
    localparam int STATUS_ILLEGAL = 0;
    localparam int NUM_GPR = 8;
    localparam logic [2:0] SP_INDEX = 3'h7;
    localparam logic [31:0] STEP_WORD = 32'h0000_0002;
    localparam logic [31:0] STEP_LONG = 32'h0000_0004;
    localparam logic [7:0] BCD_LIMIT = 8'h99;
    localparam logic [3:0] NIBBLE_LIMIT = 4'h9;
    localparam logic [3:0] BCD_FIX = 4'h6;

    typedef enum logic [4:0] {
        mov_reg, mov_load, mov_store, pop_reg, push_reg,
        move_from_peripheral_sync, move_to_peripheral_sync,
        add_plain, sub_plain, add_with_carry, subtract_with_borrow,
        inc_reg, dec_reg, address_adjust_add, address_adjust_sub,
        decimal_adjust_add, decimal_adjust_sub, multiply_unsigned, multiply_signed
    } op_type;

    typedef enum logic [1:0] {byte_size, word_size, long_size} size_type;
    typedef enum logic [1:0] {len_3, len_8, len_16, len_24} len_type;

    // Command word as written to OFS_CMD, bit 0 at the bottom
    typedef struct packed {
        logic [13:0] spare;
        len_type len;
        logic imm;
        logic [3:0] src;
        logic [3:0] dst;
        size_type size;
        op_type op;
    } cmd_type;

    typedef struct packed {
        logic n;
        logic z;
        logic v;
        logic c;
    } flags_type;

    typedef struct packed {
        logic [31:0] r;
        flags_type f;
    } result_type;

    typedef struct packed {
        logic [NUM_GPR-1:0][31:0] gpr;
        flags_type flags;
        logic illegal;
        logic [31:0] cmd;
        logic [31:0] data;
        logic [31:0] disp;
        logic [31:0] maddr;
        logic [31:0] mwdata;
        logic ready;
        logic slverr;
        logic [31:0] rdata;
    } state_type;

    // All registers, flags and status clear at reset
    localparam state_type STATE_RESET = '0;
endpackage: dp_pkg

/* verif/testbench.sv */
// Self-checking bench for the transfer and arithmetic datapath, driven over APB.
// Assumes the register map and command encoding of dp_pkg; the master waits for pready.
module testbench;
    timeunit 1ns;
    timeprecision 100ps;

    // Clock, reset and bus
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [3:0] pstrb = 4'hF;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    int num_errors = 0;
    int total_checks = 0;

    cpu_transfer_arith_datapath cpu_transfer_arith_datapath_i (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .pstrb(pstrb),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr)
    );

    always #2 pclk = ~pclk;

    task automatic give_verdict;
        if (num_errors == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask: give_verdict

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask: chk

    // One APB transfer; the answer is taken at the rising edge where pready is sampled high
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] r, output logic e);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 20)
        begin
            @(posedge pclk);
            n++;
        end
        if (n >= 20)
            num_errors++;
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask: xfer

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        xfer(1'b1, a, d, r, e);
        chk({31'h0, e}, 32'h0);
    endtask: wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic exp_err = 1'b0);
        logic [31:0] r;
        logic e;
        xfer(1'b0, a, 32'h0, r, e);
        chk({31'h0, e}, {31'h0, exp_err});
        chk(r, exp);
    endtask: rd

    function automatic logic [7:0] gpr(input int n);
        return 8'(32 + 4 * n);
    endfunction: gpr

    // Executes one command word built from its fields
    task automatic run(input dp_pkg::op_type o, input dp_pkg::size_type s, input logic [3:0] d,
                       input logic [3:0] sr, input logic im = 1'b0, input dp_pkg::len_type l = dp_pkg::len_8);
        dp_pkg::cmd_type c;
        c = '0;
        c.op = o;
        c.size = s;
        c.dst = d;
        c.src = sr;
        c.imm = im;
        c.len = l;
        wr(dp_pkg::OFS_CMD, c);
    endtask: run

    // Illegal command must leave the status bit set; clear it again afterwards
    task automatic expect_refused;
        rd(dp_pkg::OFS_STATUS, 32'h0000_0001);
        wr(dp_pkg::OFS_STATUS, 32'h0000_0001);
        rd(dp_pkg::OFS_STATUS, 32'h0000_0000);
    endtask: expect_refused

    initial
    begin
        #(20000 * 4);
        num_errors++;
        give_verdict();
    end

    initial
    begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        rd(gpr(0), 32'h0000_0000);
        rd(dp_pkg::OFS_FLAGS, 32'h0000_0000);
        rd(8'hFC, 32'h0000_0000, 1'b1);
        wr(gpr(0), 32'h1234_5678);
        wr(dp_pkg::OFS_DATA, 32'h0000_00AB);
        run(dp_pkg::mov_reg, dp_pkg::byte_size, 4'h8, 4'h0, 1'b1);
        rd(gpr(0), 32'h1234_56AB);
        wr(dp_pkg::OFS_DATA, 32'h0000_BEEF);
        run(dp_pkg::mov_reg, dp_pkg::word_size, 4'h8, 4'h0, 1'b1);
        rd(gpr(0), 32'hBEEF_56AB);
        wr(gpr(1), 32'h7FFF_FFFF);
        wr(gpr(2), 32'h0000_0001);
        run(dp_pkg::add_plain, dp_pkg::long_size, 4'h1, 4'h2);
        rd(gpr(1), 32'h8000_0000);
        rd(dp_pkg::OFS_FLAGS, 32'h0000_000A);
        wr(dp_pkg::OFS_FLAGS, 32'h0000_0001);
        wr(dp_pkg::OFS_DATA, 32'h0000_0005);
        run(dp_pkg::add_with_carry, dp_pkg::byte_size, 4'h9, 4'h0, 1'b1);
        rd(gpr(1), 32'h8000_0006);
        rd(dp_pkg::OFS_FLAGS, 32'h0000_0000);
        run(dp_pkg::sub_plain, dp_pkg::byte_size, 4'h9, 4'h0, 1'b1);
        expect_refused();
        rd(gpr(1), 32'h8000_0006);
        run(dp_pkg::move_from_peripheral_sync, dp_pkg::byte_size, 4'h9, 4'h0);
        expect_refused();
        run(dp_pkg::move_to_peripheral_sync, dp_pkg::byte_size, 4'h0, 4'h9);
        expect_refused();
        run(dp_pkg::inc_reg, dp_pkg::word_size, 4'h2, 4'h2);
        rd(gpr(2), 32'h0000_0003);
        run(dp_pkg::inc_reg, dp_pkg::byte_size, 4'hA, 4'h2);
        expect_refused();
        run(dp_pkg::address_adjust_sub, dp_pkg::long_size, 4'h2, 4'h4);
        rd(gpr(2), 32'hFFFF_FFFF);
        wr(gpr(3), 32'h0000_00FF);
        wr(gpr(4), 32'h0000_00FF);
        run(dp_pkg::multiply_unsigned, dp_pkg::word_size, 4'h3, 4'h4);
        rd(gpr(3), 32'h0000_FE01);
        wr(gpr(5), 32'h0000_FFFF);
        wr(gpr(6), 32'h0000_0002);
        run(dp_pkg::multiply_signed, dp_pkg::word_size, 4'h5, 4'h6);
        rd(gpr(5), 32'hFFFF_FFFE);
        wr(gpr(0), 32'h0000_000F);
        wr(dp_pkg::OFS_FLAGS, 32'h0000_0000);
        run(dp_pkg::decimal_adjust_add, dp_pkg::byte_size, 4'h8, 4'h0);
        rd(gpr(0), 32'h0000_0015);
        wr(gpr(7), 32'h0000_0100);
        run(dp_pkg::push_reg, dp_pkg::long_size, 4'h0, 4'h1);
        rd(gpr(7), 32'h0000_00FC);
        rd(dp_pkg::OFS_MADDR, 32'h0000_00FC);
        rd(dp_pkg::OFS_MWDATA, 32'h8000_0006);
        wr(dp_pkg::OFS_DATA, 32'h0000_1234);
        run(dp_pkg::pop_reg, dp_pkg::word_size, 4'h5, 4'h0);
        rd(dp_pkg::OFS_MADDR, 32'h0000_00FC);
        rd(gpr(7), 32'h0000_00FE);
        rd(gpr(5), 32'hFFFF_1234);
        wr(dp_pkg::OFS_DISP, 32'h00AB_CDEF);
        wr(dp_pkg::OFS_DATA, 32'hCAFE_F00D);
        run(dp_pkg::mov_load, dp_pkg::long_size, 4'h6, 4'h0, 1'b1, dp_pkg::len_24);
        rd(dp_pkg::OFS_MADDR, 32'h00AB_CDEF);
        rd(gpr(6), 32'hCAFE_F00D);
        wr(gpr(0), 32'hA5A5_00FB);
        run(dp_pkg::address_adjust_add, dp_pkg::long_size, 4'h0, 4'h4);
        rd(gpr(0), 32'hA5A5_00FF);
        run(dp_pkg::inc_reg, dp_pkg::byte_size, 4'h8, 4'h1);
        rd(gpr(0), 32'hA5A5_0000);
        rd(dp_pkg::OFS_FLAGS, 32'h0000_0004);
        wr(gpr(0), 32'hA5A5_00F0);
        run(dp_pkg::multiply_unsigned, dp_pkg::byte_size, 4'h0, 4'h9);
        rd(gpr(0), 32'hA5A5_05A0);
        run(dp_pkg::add_plain, dp_pkg::long_size, 4'h0, 4'h1);
        rd(gpr(0), 32'h25A5_05A6);
        rd(dp_pkg::OFS_FLAGS, 32'h0000_0003);
        run(dp_pkg::subtract_with_borrow, dp_pkg::byte_size, 4'h8, 4'h9);
        rd(gpr(0), 32'h25A5_059F);
        rd(dp_pkg::OFS_FLAGS, 32'h0000_0008);
        run(dp_pkg::decimal_adjust_sub, dp_pkg::byte_size, 4'h8, 4'h0);
        rd(gpr(0), 32'h25A5_0599);
        run(dp_pkg::dec_reg, dp_pkg::long_size, 4'h0, 4'h1);
        rd(gpr(0), 32'h25A5_0598);
        run(dp_pkg::multiply_signed, dp_pkg::byte_size, 4'h0, 4'h9);
        rd(gpr(0), 32'h25A5_FD90);
        run(dp_pkg::mov_store, dp_pkg::word_size, 4'h7, 4'h8);
        rd(dp_pkg::OFS_MADDR, 32'h0000_00ED);
        rd(dp_pkg::OFS_MWDATA, 32'h0000_25A5);
        give_verdict();
    end
endmodule: testbench
